// ### rtl/sdt_pkg.sv
// Purpose: Shared constants for the standard timer mode logic
// Assumes: One timer clock, 16-bit counter, 8-bit period compare value
// Notes: Mode and pin-function encodings as seen on the control inputs
package sdt_pkg;
	localparam int CNT_W = 16;
	localparam int TGT_W = 17;
	localparam int CP_W = 8;
	localparam int SYNC_W = 2;

	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CP_W-1:0] CP_ZERO = 8'h00;
	localparam logic [TGT_W-1:0] TGT_FULL = 17'h10000;
	localparam logic [TGT_W-1:0] TGT_ONE = 17'h00001;

	// Operating modes on {mode_select_hi, mode_select_lo}
	typedef enum logic [1:0] {
		SDT_MODE_CMP = 2'h0,
		SDT_MODE_CAP = 2'h1,
		SDT_MODE_PWM = 2'h2,
		SDT_MODE_TMR = 2'h3
	} sdt_mode_t;

	// Pin-function codes on {pin_function_hi, pin_function_lo}
	localparam logic [1:0] PF_00 = 2'h0;
	localparam logic [1:0] PF_01 = 2'h1;
	localparam logic [1:0] PF_10 = 2'h2;
	localparam logic [1:0] PF_11 = 2'h3;

	// Span of the period compare value in clocks; zero means full range
	function automatic logic [TGT_W-1:0] sdt_p_span(input logic [CP_W-1:0] cp);
		logic [TGT_W-1:0] span;
		span = {1'b0, cp, 8'h00};
		if (cp == CP_ZERO) begin
			span = TGT_FULL;
		end
		return span;
	endfunction : sdt_p_span
endpackage : sdt_pkg

// ### rtl/sdt_sync.sv
// Purpose: Three-flop synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to mclk
// Notes: Output moves only when the second and third stages agree
module sdt_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic q_r;
			logic q_nxt;
			always_comb begin
				q_nxt = q_r;
				if (s2_r == s3_r) begin
					q_nxt = s3_r;
				end
			end
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
					q_r <= 1'b0;
				end else begin
					s1_r <= din[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
					q_r <= q_nxt;
				end
			end
			assign dout[i] = q_r;
		end
	endgenerate
endmodule : sdt_sync

// ### rtl/sdt_match.sv
// Purpose: Comparator that fires on the last count before a target
// Assumes: Target is 1 to 65536 clocks, wider by one bit than the counter
// Notes: A target of 65536 fires at the full-count overflow
module sdt_match (
	// Counter and target
	input wire logic [sdt_pkg::CNT_W-1:0] cnt,
	input wire logic [sdt_pkg::TGT_W-1:0] target,
	// Result
	output logic hit
);
	logic [sdt_pkg::TGT_W-1:0] cnt_inc;
	assign cnt_inc = {1'b0, cnt} + sdt_pkg::TGT_ONE;
	assign hit = (cnt_inc == target);
endmodule : sdt_match

// ### rtl/sdt_timer.sv
// Purpose: Mode logic of a 16-bit standard timer
// Assumes: mclk is the selected timer clock; control bits are stable levels
// Notes: Flags are sticky, cleared by one-cycle clear inputs
//
// Function
// - Compare mode: clear select picks A match
// - Clear select high suppresses P flag
// - Compare pin changes only on A match
// - Run rising edge restores initial pin level
// - Mode 11 counts like compare, pin unused
// - PWM ignores clear select; swap picks roles
// - Swap 0: period P times 256, duty A
// - Duty at least period gives full duty
// - Swap 1: period A, duty P times 256
// - PWM raises both flags on matches, except single pulse (A flag only)
// - PWM level, invert and fixed levels
// - Fixed PWM levels keep counting and flags
// - Run rising edge starts pulse, clears counter
// - Trigger pin edge sets run in single pulse
// - A match ends pulse, clears run, flags
// - Single pulse: counter cleared only at start
// - Mode 01 capture; pins 11 disable capture
// - Capture copies counter to A, flags
// - Capture counter wraps on P match, flags
// - Capture ignores output bits, no pin drive
// - P value compares upper byte, zero overflows
// - Output control 0 active low, 1 high
module sdt_timer (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Run bit access
	input wire logic run_wr_en,
	input wire logic run_wr_data,
	output logic run_bit,
	// Mode and pin configuration
	input wire logic mode_select_hi,
	input wire logic mode_select_lo,
	input wire logic pin_function_hi,
	input wire logic pin_function_lo,
	input wire logic output_control_level,
	input wire logic output_invert,
	input wire logic duty_period_swap,
	input wire logic counter_clear_select,
	// Compare values
	input wire logic ca_wr_en,
	input wire logic [sdt_pkg::CNT_W-1:0] ca_wr_data,
	output logic [sdt_pkg::CNT_W-1:0] compare_a_value,
	input wire logic [sdt_pkg::CP_W-1:0] compare_p_value,
	// Counter view
	output logic [sdt_pkg::CNT_W-1:0] count_value,
	// Flags
	input wire logic match_a_clr,
	input wire logic match_p_clr,
	output logic match_a_flag,
	output logic match_p_flag,
	// Pins
	input wire logic external_trigger_pin,
	input wire logic capture_input_pin,
	output logic timer_out,
	output logic timer_out_oe
);
	logic rst_s1_r;
	logic rst_n;
	logic [sdt_pkg::SYNC_W-1:0] pin_sync;
	logic trig_lvl;
	logic cap_lvl;
	logic trig_prev_r;
	logic trig_prev_nxt;
	logic cap_prev_r;
	logic cap_prev_nxt;

	logic run_r;
	logic run_nxt;
	logic run_prev_r;
	logic run_prev_nxt;
	logic [sdt_pkg::CNT_W-1:0] cnt_r;
	logic [sdt_pkg::CNT_W-1:0] cnt_nxt;
	logic [sdt_pkg::CNT_W-1:0] ca_r;
	logic [sdt_pkg::CNT_W-1:0] ca_nxt;
	logic fa_r;
	logic fa_nxt;
	logic fp_r;
	logic fp_nxt;
	logic lvl_r;
	logic lvl_nxt;
	logic pin_r;
	logic pin_nxt;
	logic oe_r;
	logic oe_nxt;

	sdt_pkg::sdt_mode_t mode;
	logic [1:0] pf;
	logic run_rise;
	logic single;
	logic hit_a;
	logic hit_p;
	logic [sdt_pkg::TGT_W-1:0] tgt_a;
	logic [sdt_pkg::TGT_W-1:0] tgt_p;
	logic [sdt_pkg::TGT_W-1:0] duty;
	logic cnt_clr;
	logic set_a;
	logic set_p;
	logic cap_edge;
	logic trig_edge;
	logic act;

	// Reset release
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// Pin synchronisers
	sdt_sync #(
		.W(sdt_pkg::SYNC_W)
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.din({capture_input_pin, external_trigger_pin}),
		.dout(pin_sync)
	);
	assign trig_lvl = pin_sync[0];
	assign cap_lvl = pin_sync[1];

	// Comparators
	assign tgt_a = {1'b0, ca_r};
	assign tgt_p = sdt_pkg::sdt_p_span(compare_p_value);

	sdt_match u_match_a (
		.cnt(cnt_r),
		.target(tgt_a),
		.hit(hit_a)
	);

	sdt_match u_match_p (
		.cnt(cnt_r),
		.target(tgt_p),
		.hit(hit_p)
	);

	// Decode
	assign mode = sdt_pkg::sdt_mode_t'({mode_select_hi, mode_select_lo});
	assign pf = {pin_function_hi, pin_function_lo};
	assign single = (mode == sdt_pkg::SDT_MODE_PWM) && (pf == sdt_pkg::PF_11);
	assign run_rise = run_r && !run_prev_r;
	assign trig_edge = trig_lvl && !trig_prev_r;
	assign duty = duty_period_swap ? tgt_p : tgt_a;

	// Event decode per mode
	always_comb begin
		cnt_clr = 1'b0;
		set_a = 1'b0;
		set_p = 1'b0;
		cap_edge = 1'b0;
		case (mode)
			sdt_pkg::SDT_MODE_CMP, sdt_pkg::SDT_MODE_TMR: begin
				cnt_clr = counter_clear_select ? hit_a : hit_p;
				set_a = hit_a;
				set_p = hit_p && !counter_clear_select;
			end
			sdt_pkg::SDT_MODE_CAP: begin
				case (pf)
					sdt_pkg::PF_00: cap_edge = cap_lvl && !cap_prev_r;
					sdt_pkg::PF_01: cap_edge = !cap_lvl && cap_prev_r;
					sdt_pkg::PF_10: cap_edge = cap_lvl != cap_prev_r;
					default: cap_edge = 1'b0;
				endcase
				cnt_clr = hit_p;
				set_a = cap_edge;
				set_p = hit_p;
			end
			sdt_pkg::SDT_MODE_PWM: begin
				if (single) begin
					set_a = hit_a;
				end else begin
					cnt_clr = duty_period_swap ? hit_a : hit_p;
					set_a = hit_a;
					set_p = hit_p;
				end
			end
			default: begin
				cnt_clr = 1'b0;
			end
		endcase
		if (!run_r || run_rise) begin
			cnt_clr = 1'b0;
			set_a = 1'b0;
			set_p = 1'b0;
			cap_edge = 1'b0;
		end
	end

	// Run bit, counter, capture and flags
	always_comb begin
		run_prev_nxt = run_r;
		trig_prev_nxt = trig_lvl;
		cap_prev_nxt = cap_lvl;
		run_nxt = run_r;
		if (run_wr_en) begin
			run_nxt = run_wr_data;
		end
		if (single && trig_edge && !run_r) begin
			run_nxt = 1'b1;
		end
		if (single && set_a) begin
			run_nxt = 1'b0;
		end
		cnt_nxt = cnt_r;
		if (run_rise) begin
			cnt_nxt = sdt_pkg::CNT_RST;
		end else if (run_r) begin
			if (cnt_clr) begin
				cnt_nxt = sdt_pkg::CNT_RST;
			end else begin
				cnt_nxt = cnt_r + sdt_pkg::CNT_ONE;
			end
		end
		ca_nxt = ca_r;
		if (ca_wr_en) begin
			ca_nxt = ca_wr_data;
		end
		if (cap_edge) begin
			ca_nxt = cnt_r;
		end
		fa_nxt = set_a || (fa_r && !match_a_clr);
		fp_nxt = set_p || (fp_r && !match_p_clr);
	end

	// Output pin
	always_comb begin
		lvl_nxt = lvl_r;
		pin_nxt = 1'b0;
		oe_nxt = 1'b0;
		act = ({1'b0, cnt_nxt} < duty) && run_nxt;
		case (mode)
			sdt_pkg::SDT_MODE_CMP: begin
				oe_nxt = 1'b1;
				if (run_rise) begin
					lvl_nxt = output_control_level;
				end else if (set_a) begin
					case (pf)
						sdt_pkg::PF_01: lvl_nxt = 1'b0;
						sdt_pkg::PF_10: lvl_nxt = 1'b1;
						sdt_pkg::PF_11: lvl_nxt = !lvl_r;
						default: lvl_nxt = lvl_r;
					endcase
				end
				pin_nxt = lvl_nxt ^ output_invert;
			end
			sdt_pkg::SDT_MODE_PWM: begin
				oe_nxt = 1'b1;
				case (pf)
					sdt_pkg::PF_00: pin_nxt = !output_control_level;
					sdt_pkg::PF_01: pin_nxt = output_control_level;
					sdt_pkg::PF_10: pin_nxt = act ? output_control_level : !output_control_level;
					default: pin_nxt = run_nxt ? output_control_level : !output_control_level;
				endcase
				pin_nxt = pin_nxt ^ output_invert;
			end
			default: begin
				pin_nxt = 1'b0;
				oe_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 1'b0;
			run_prev_r <= 1'b0;
			trig_prev_r <= 1'b0;
			cap_prev_r <= 1'b0;
			cnt_r <= sdt_pkg::CNT_RST;
			ca_r <= sdt_pkg::CNT_RST;
			fa_r <= 1'b0;
			fp_r <= 1'b0;
			lvl_r <= 1'b0;
			pin_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
			run_prev_r <= run_prev_nxt;
			trig_prev_r <= trig_prev_nxt;
			cap_prev_r <= cap_prev_nxt;
			cnt_r <= cnt_nxt;
			ca_r <= ca_nxt;
			fa_r <= fa_nxt;
			fp_r <= fp_nxt;
			lvl_r <= lvl_nxt;
			pin_r <= pin_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign run_bit = run_r;
	assign compare_a_value = ca_r;
	assign count_value = cnt_r;
	assign match_a_flag = fa_r;
	assign match_p_flag = fp_r;
	assign timer_out = pin_r;
	assign timer_out_oe = oe_r;
endmodule : sdt_timer

// ### sim/sdt_timer_monitor.sv
// Purpose: Port checker for the standard timer mode logic
// Assumes: Config bits change only while the run bit is low
// Notes: Bound to sdt_timer at the foot of this file
module sdt_timer_monitor (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Control
	input wire logic run_wr_en,
	input wire logic mode_select_hi,
	input wire logic mode_select_lo,
	input wire logic pin_function_hi,
	input wire logic pin_function_lo,
	input wire logic output_control_level,
	input wire logic output_invert,
	input wire logic counter_clear_select,
	input wire logic ca_wr_en,
	input wire logic [7:0] compare_p_value,
	// Status
	input wire logic run_bit,
	input wire logic [15:0] compare_a_value,
	input wire logic [15:0] count_value,
	input wire logic match_a_flag,
	input wire logic match_p_flag,
	input wire logic timer_out,
	input wire logic timer_out_oe
);
	wire logic [3:0] mp = {mode_select_hi, mode_select_lo, pin_function_hi, pin_function_lo};
	wire logic a_hit = run_bit && (count_value + 16'h0001 == compare_a_value);
	wire logic lvl = output_control_level ^ output_invert;
	default clocking mon_cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	AST_CCLR_A: assert property (mp[3:2] == 2'h0 && counter_clear_select && a_hit
		&& !run_wr_en |=> count_value == 16'h0000) else $error("no clear on A match");
	AST_NO_PFLAG: assert property (mp[3:2] == 2'h0 && counter_clear_select
		&& !match_p_flag |=> !match_p_flag) else $error("P flag raised");
	AST_PIN_HOLD: assert property (mp[3:2] == 2'h0 && run_bit && !a_hit && !run_wr_en
		&& !$rose(run_bit) |=> $stable(timer_out)) else $error("pin moved without A match");
	AST_RUN_INIT: assert property (mp[3:2] == 2'h0 && $rose(run_bit)
		|=> timer_out == lvl) else $error("pin not at initial level");
	AST_TMR_PIN: assert property (mp[3:2] == 2'h3
		|=> !timer_out_oe && !timer_out) else $error("pin driven in timer mode");
	AST_CAP_PIN: assert property (mp[3:2] == 2'h1 |=> !timer_out_oe)
		else $error("pin driven in capture mode");
	AST_PWM_FIXED: assert property (mp[3:2] == 2'h2 && !mp[1] && run_bit [*3]
		|-> timer_out == (mp[0] ? lvl : !lvl)) else $error("fixed pin level wrong");
	AST_SP_END: assert property (mp == 4'hB && a_hit && !$rose(run_bit)
		|=> !run_bit && match_a_flag) else $error("pulse not ended on A match");
	AST_CAP_COPY: assert property (mp[3:2] == 2'h1 && !ca_wr_en ##1
		compare_a_value != $past(compare_a_value)
		|-> compare_a_value == $past(count_value) && match_a_flag) else $error("bad capture");
	AST_CAP_WRAP: assert property (mp[3:2] == 2'h1 && run_bit && !run_wr_en
		&& !$rose(run_bit) && count_value == {compare_p_value - 8'h01, 8'hFF}
		|=> count_value == 16'h0000 && match_p_flag) else $error("no wrap on P match");
	COV_SP: cover property (mp == 4'hB && $rose(run_bit));
	COV_PWM: cover property (mp == 4'hA && $rose(timer_out));
	COV_CAP: cover property (mp[3:2] == 2'h1 && $rose(match_a_flag));
endmodule : sdt_timer_monitor

bind sdt_timer sdt_timer_monitor u_mon (.mclk(mclk), .arst_n(arst_n), .run_wr_en(run_wr_en),
	.mode_select_hi(mode_select_hi), .mode_select_lo(mode_select_lo),
	.pin_function_hi(pin_function_hi), .pin_function_lo(pin_function_lo),
	.output_control_level(output_control_level), .output_invert(output_invert),
	.counter_clear_select(counter_clear_select), .ca_wr_en(ca_wr_en),
	.compare_p_value(compare_p_value), .run_bit(run_bit), .compare_a_value(compare_a_value),
	.count_value(count_value), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag),
	.timer_out(timer_out), .timer_out_oe(timer_out_oe));

// ### sim/sdt_pins.sv
// Purpose: Far-side pins: trigger source and capture signal
// Assumes: Pins change at an offset unrelated to mclk
// Notes: Trigger pin stays high seven cycles per request
module sdt_pins (
	// Clock
	input wire logic mclk,
	// Requests from the bench
	input wire logic trig_req,
	input wire logic cap_lvl,
	// Pins
	output logic external_trigger_pin = 1'b0,
	output logic capture_input_pin = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] hold_r = 3'h0;
	always @(posedge mclk) begin
		hold_r <= trig_req ? 3'h7 : hold_r - 3'(hold_r != 3'h0);
		external_trigger_pin <= #37 (hold_r != 3'h0);
		capture_input_pin <= #53 cap_lvl;
	end
endmodule : sdt_pins

// ### sim/testbench.sv
// Purpose: Directed bench for the standard timer mode logic
// Assumes: 10 MHz mclk, config changed only while stopped
// Notes: cfg is {mode hi, lo, pin fn hi, lo, level, invert, swap, clear select}
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, arst_n, run_wr_en, run_wr_data, run_bit, ca_wr_en, match_a_clr, match_p_clr;
	logic match_a_flag, match_p_flag, external_trigger_pin, capture_input_pin, timer_out;
	logic timer_out_oe, trig_req, cap_lvl;
	logic [7:0] cfg, compare_p_value;
	logic [15:0] ca_wr_data, compare_a_value, count_value;
	int checked, miscompares;
	sdt_timer DUT (.mclk(mclk), .arst_n(arst_n), .run_wr_en(run_wr_en), .run_wr_data(run_wr_data),
		.run_bit(run_bit), .mode_select_hi(cfg[7]), .mode_select_lo(cfg[6]),
		.pin_function_hi(cfg[5]), .pin_function_lo(cfg[4]), .output_control_level(cfg[3]),
		.output_invert(cfg[2]), .duty_period_swap(cfg[1]), .counter_clear_select(cfg[0]),
		.ca_wr_en(ca_wr_en), .ca_wr_data(ca_wr_data), .compare_a_value(compare_a_value),
		.compare_p_value(compare_p_value), .count_value(count_value),
		.match_a_clr(match_a_clr), .match_p_clr(match_p_clr),
		.match_a_flag(match_a_flag), .match_p_flag(match_p_flag),
		.external_trigger_pin(external_trigger_pin), .capture_input_pin(capture_input_pin),
		.timer_out(timer_out), .timer_out_oe(timer_out_oe));
	sdt_pins u_pins (.mclk(mclk), .trig_req(trig_req), .cap_lvl(cap_lvl),
		.external_trigger_pin(external_trigger_pin), .capture_input_pin(capture_input_pin));
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task automatic run_set(input logic v);
		if (!mclk) @(posedge mclk);
		run_wr_en <= 1'b1;
		run_wr_data <= v;
		cyc(1);
		run_wr_en <= 1'b0;
	endtask : run_set
	// Stop, load config and compare A, clear flags, then write run
	task automatic setup(input logic [7:0] c, input logic [15:0] a, input logic [7:0] p,
		input logic go);
		run_set(1'b0);
		cfg <= c;
		compare_p_value <= p;
		ca_wr_en <= 1'b1;
		ca_wr_data <= a;
		match_a_clr <= 1'b1;
		match_p_clr <= 1'b1;
		cyc(1);
		ca_wr_en <= 1'b0;
		match_a_clr <= 1'b0;
		match_p_clr <= 1'b0;
		run_set(go);
	endtask : setup
	task automatic t_cmp;
		setup(8'h39, 16'h0200, 8'h01, 1'b1);
		cyc(2);
		@(negedge mclk);
		`CHK({timer_out, timer_out_oe}, 2'h3)
		cyc(288);
		@(negedge mclk);
		`CHK(timer_out, 1'b1)
		cyc(240);
		@(negedge mclk);
		`CHK({timer_out, match_a_flag, match_p_flag}, 3'h2)
		`CHK(count_value < 16'h0200, 1'b1)
		run_set(1'b0);
		cyc(1);
		run_set(1'b1);
		cyc(2);
		@(negedge mclk);
		`CHK(timer_out, 1'b1)
	endtask : t_cmp
	task automatic t_tmr;
		setup(8'hC0, 16'h0040, 8'h01, 1'b1);
		cyc(300);
		@(negedge mclk);
		`CHK({match_a_flag, match_p_flag, timer_out_oe}, 3'h6)
	endtask : t_tmr
	// Count active cycles over a window of whole periods
	task automatic t_pwm(input logic [7:0] c, input logic [15:0] a, input int win, input int hi,
		input logic [1:0] fl);
		int n;
		setup(c, a, 8'h01, 1'b1);
		cyc(300);
		n = 0;
		repeat (win) begin
			@(negedge mclk);
			n += int'(timer_out === 1'b1);
		end
		`CHK(n, hi)
		`CHK({match_a_flag, match_p_flag}, fl)
	endtask : t_pwm
	task automatic t_sp;
		int n;
		int m;
		setup(8'hB8, 16'h0020, 8'h00, 1'b0);
		trig_req <= 1'b1;
		cyc(1);
		trig_req <= 1'b0;
		n = 0;
		m = 0;
		repeat (60) begin
			@(negedge mclk);
			n += int'(run_bit === 1'b1);
			m += int'(timer_out === 1'b1);
		end
		`CHK(n, 33)
		`CHK(m, n)
		`CHK({run_bit, match_a_flag, timer_out}, 3'h2)
		cyc(1);
		run_set(1'b1);
		cyc(5);
		@(negedge mclk);
		`CHK(timer_out, 1'b1)
	endtask : t_sp
	task automatic t_cap;
		for (int e = 0; e < 4; e++) begin
			setup({2'h1, 2'(e), 4'hF}, 16'h1234, 8'h01, 1'b1);
			cyc(40);
			cap_lvl <= 1'b1;
			cyc(10);
			@(negedge mclk);
			`CHK(match_a_flag, 1'(e == 0 || e == 2))
			cyc(1);
			cap_lvl <= 1'b0;
			cyc(10);
			@(negedge mclk);
			`CHK(match_a_flag, 1'(e != 3))
			`CHK(compare_a_value !== 16'h1234, 1'(e != 3))
		end
		cyc(300);
		@(negedge mclk);
		`CHK(match_p_flag, 1'b1)
	endtask : t_cap
	task automatic close_out;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		arst_n = 1'b0;
		run_wr_en = 1'b0;
		run_wr_data = 1'b0;
		ca_wr_en = 1'b0;
		ca_wr_data = 16'h0000;
		match_a_clr = 1'b0;
		match_p_clr = 1'b0;
		cfg = 8'h00;
		compare_p_value = 8'h00;
		trig_req = 1'b0;
		cap_lvl = 1'b0;
		cyc(6);
		arst_n <= 1'b1;
		cyc(3);
		t_cmp();
		t_tmr();
		t_pwm(8'hA5, 16'h0040, 256, 64, 2'h3);
		t_pwm(8'hAA, 16'h0300, 768, 256, 2'h3);
		t_pwm(8'hA8, 16'h0200, 256, 256, 2'h1);
		t_pwm(8'h88, 16'h0040, 256, 0, 2'h3);
		t_sp();
		t_cap();
		close_out();
	end
	// Tests need about 4200 cycles; allow nearly five times that
	initial begin
		#2000000;
		miscompares++;
		close_out();
	end
endmodule : testbench
